/* core/css_sequencer.v */
// Purpose: Charge state sequencer with overcharge timer and APB status
// Assumes: All inputs synchronous to mclk; comparators already digital
// Notes:   Charge request is an open-drain pin, pulled low on expiry
//
// Behaviour
// - Rising charge request starts a cycle; states then advance in order.
// - Trickle state drives both phase flags low.
// - Trickle sense met leaves trickle for bulk; skips trickle if met.
// - Bulk state drives flag a high, flag b low.
// - Voltage comparator at 95 percent moves bulk to overcharge.
// - Entering overcharge drives flag a low, flag b high.
// - Near-full comparator in overcharge drives both flags high.
// - Overcharge timer is a 14-bit counter on a slow tick.
// - Timer starts on overcharge entry and runs until expiry.
// - Charging continues after near-full until expiry or battery removal.
// - On expiry the device pulls the charge request pin low through its open-drain output.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "css_defs.vh"

module css_sequencer #(
	parameter TBITS = `CSS_TIMER_BITS,
	parameter DBITS = 16
) (
	input  wire        mclk,
	input  wire        nrst,
	input  wire        ce,
	input  wire        charge_request_in,
	output wire        charge_request_out,
	output wire        charge_request_oe,
	input  wire        trickle_sense_input,
	input  wire        volt_at_95,
	input  wire        near_full_level,
	input  wire        battery_present,
	output reg         phase_flag_a,
	output reg         phase_flag_b,
	output reg         charging,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr
);

	// --------------------------------------------------------
	// State and timer
	// --------------------------------------------------------
	reg  [2:0]       state;
	reg  [2:0]       next_state;
	reg              req_q;
	reg  [TBITS-1:0] timer;
	reg              timer_wrap;
	reg              pull_low;
	reg  [DBITS-1:0] tdiv;
	reg              abort;
	wire             tick;
	wire             req_rise;
	wire             timer_run;
	wire             expired;

	assign req_rise  = charge_request_in & ~req_q;
	assign timer_run = (state == `CSS_ST_OVER) |
	                   (state == `CSS_ST_NEARFULL);
	assign expired   = timer_run & tick &
	                   (timer == {TBITS{1'b1}});

	// Open drain: drive low only, host reads the line level
	assign charge_request_out = 1'b0;
	assign charge_request_oe  = pull_low;

	css_tick_div #(
		.WIDTH     (DBITS)
	) u_div (
		.mclk      (mclk),
		.nrst      (nrst),
		.ce        (ce),
		.run       (timer_run),
		.div_value (tdiv),
		.tick      (tick)
	);

	always @*
	begin
		next_state = state;
		case (state)
		`CSS_ST_IDLE:
			if (req_rise && battery_present)
				next_state = trickle_sense_input ? `CSS_ST_BULK
				                                 : `CSS_ST_TRICKLE;
		`CSS_ST_TRICKLE:
			if (trickle_sense_input)
				next_state = `CSS_ST_BULK;
		`CSS_ST_BULK:
			if (volt_at_95)
				next_state = `CSS_ST_OVER;
		`CSS_ST_OVER:
			if (near_full_level)
				next_state = `CSS_ST_NEARFULL;
		`CSS_ST_NEARFULL:
			next_state = `CSS_ST_NEARFULL;
		`CSS_ST_DONE:
			if (req_rise && battery_present)
				next_state = trickle_sense_input ? `CSS_ST_BULK
				                                 : `CSS_ST_TRICKLE;
		default:
			next_state = `CSS_ST_IDLE;
		endcase
		if (state != `CSS_ST_IDLE && state != `CSS_ST_DONE)
		begin
			if (expired)
				next_state = `CSS_ST_DONE;
			if (!battery_present || !charge_request_in || abort)
				next_state = `CSS_ST_IDLE;
		end
	end

	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			state      <= `CSS_ST_IDLE;
			req_q      <= 1'b0;
			timer      <= {TBITS{1'b0}};
			timer_wrap <= 1'b0;
			pull_low   <= 1'b0;
		end
		else if (ce)
		begin
			state <= next_state;
			req_q <= charge_request_in;
			if (!timer_run)
				timer <= {TBITS{1'b0}};
			else if (tick)
				timer <= timer + {{(TBITS-1){1'b0}}, 1'b1};
			timer_wrap <= expired;
			if (expired)
				pull_low <= 1'b1;
			else if (req_rise || !battery_present)
				pull_low <= 1'b0;
		end
	end

	// --------------------------------------------------------
	// Status flags
	// --------------------------------------------------------
	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			phase_flag_a <= 1'b0;
			phase_flag_b <= 1'b0;
			charging     <= 1'b0;
		end
		else if (ce)
		begin
			charging <= (next_state != `CSS_ST_IDLE) &&
			            (next_state != `CSS_ST_DONE);
			case (next_state)
			`CSS_ST_TRICKLE:
			begin
				phase_flag_a <= 1'b0;
				phase_flag_b <= 1'b0;
			end
			`CSS_ST_BULK:
			begin
				phase_flag_a <= 1'b1;
				phase_flag_b <= 1'b0;
			end
			`CSS_ST_OVER:
			begin
				phase_flag_a <= 1'b0;
				phase_flag_b <= 1'b1;
			end
			`CSS_ST_NEARFULL:
			begin
				phase_flag_a <= 1'b1;
				phase_flag_b <= 1'b1;
			end
			default:
			begin
				phase_flag_a <= 1'b0;
				phase_flag_b <= 1'b0;
			end
			endcase
		end
	end

	// --------------------------------------------------------
	// APB slave
	// --------------------------------------------------------
	wire wr_en;
	wire rd_en;
	wire mapped;

	assign pready  = 1'b1;
	assign mapped  = (paddr == `CSS_OFF_CTRL) |
	                 (paddr == `CSS_OFF_STATUS) |
	                 (paddr == `CSS_OFF_TIMER) |
	                 (paddr == `CSS_OFF_TDIV);
	assign pslverr = psel & penable & ~mapped;
	assign wr_en   = psel & penable & pwrite & ce;
	assign rd_en   = psel & ~penable & ~pwrite & ce;

	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			abort  <= 1'b0;
			tdiv   <= `CSS_TDIV_RESET;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			if (wr_en && paddr == `CSS_OFF_CTRL)
				abort <= pwdata[`CSS_CTRL_ABORT];
			if (wr_en && paddr == `CSS_OFF_TDIV)
				tdiv <= pwdata[DBITS-1:0];
			if (rd_en)
			begin
				prdata <= 32'h0000_0000;
				case (paddr)
				`CSS_OFF_CTRL:
					prdata[`CSS_CTRL_ABORT] <= abort;
				`CSS_OFF_STATUS:
				begin
					prdata[`CSS_STAT_FLAGA] <= phase_flag_a;
					prdata[`CSS_STAT_FLAGB] <= phase_flag_b;
					prdata[`CSS_STAT_REQIN] <= charge_request_in;
					prdata[3]               <= timer_wrap | pull_low;
					prdata[`CSS_STAT_STATE+2:`CSS_STAT_STATE] <= state;
				end
				`CSS_OFF_TIMER:
					prdata[TBITS-1:0] <= timer;
				`CSS_OFF_TDIV:
					prdata[DBITS-1:0] <= tdiv;
				default:
					prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule // css_sequencer

/* core/css_defs.vh */
// Purpose: Constants for the charge state sequencer
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH

// ------------------------------------------------------------
// State codes
// ------------------------------------------------------------
`define CSS_ST_IDLE     3'h0
`define CSS_ST_TRICKLE  3'h1
`define CSS_ST_BULK     3'h2
`define CSS_ST_OVER     3'h3
`define CSS_ST_NEARFULL 3'h4
`define CSS_ST_DONE     3'h5

// ------------------------------------------------------------
// Timer
// ------------------------------------------------------------
`define CSS_TIMER_BITS  14
`define CSS_TDIV_RESET  16'h0001

// ------------------------------------------------------------
// Register offsets and fields
// ------------------------------------------------------------
`define CSS_OFF_CTRL    12'h000
`define CSS_OFF_STATUS  12'h004
`define CSS_OFF_TIMER   12'h008
`define CSS_OFF_TDIV    12'h00C
`define CSS_CTRL_ABORT  0
`define CSS_STAT_FLAGA  0
`define CSS_STAT_FLAGB  1
`define CSS_STAT_REQIN  2
`define CSS_STAT_STATE  4

`endif

/* core/css_tick_div.v */
// Purpose: Divides mclk down to the slow overcharge timer tick
// Assumes: div_value of zero behaves as one
// Notes:   Tick is a one-cycle pulse every div_value enabled cycles
`timescale 1ns/1ps

module css_tick_div #(
	parameter WIDTH = 16
) (
	input  wire             mclk,
	input  wire             nrst,
	input  wire             ce,
	input  wire             run,
	input  wire [WIDTH-1:0] div_value,
	output reg              tick
);

	reg  [WIDTH-1:0] count;
	wire             last;

	assign last = (count + {{(WIDTH-1){1'b0}}, 1'b1}) >= div_value;

	always @(posedge mclk)
	begin
		if (!nrst)
		begin
			count <= {WIDTH{1'b0}};
			tick  <= 1'b0;
		end
		else if (ce)
		begin
			if (!run)
			begin
				count <= {WIDTH{1'b0}};
				tick  <= 1'b0;
			end
			else if (last)
			begin
				count <= {WIDTH{1'b0}};
				tick  <= 1'b1;
			end
			else
			begin
				count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
				tick  <= 1'b0;
			end
		end
	end

endmodule // css_tick_div

/* testbench/css_host_model.sv */
// Purpose: Host port and device pull-down on the charge request wire
// Assumes: Host drives the wire push-pull while the device is off it
// Notes:   Device pull-down wins over the host level
`timescale 1ns/1ps
module css_host_model (
	input  wire drive_high,
	input  wire dev_oe,
	output wire level
);
	assign level = dev_oe ? 1'b0 : drive_high;
endmodule // css_host_model

/* testbench/css_seq_props.sv */
// Purpose: Port checks for the charge state sequencer
// Assumes: Tick divider left at its reset value
// Notes:   Bound to the top module
`timescale 1ns/1ps
module css_seq_props #(
	parameter TBITS = 4
) (
	input wire mclk, nrst, ce, charge_request_in, charge_request_out,
	input wire charge_request_oe, trickle_sense_input, volt_at_95,
	input wire near_full_level, battery_present, phase_flag_a,
	input wire phase_flag_b, charging, psel, penable, pready, pslverr,
	input wire [11:0] paddr
);
	localparam int LO = (1 << TBITS) - 2;
	localparam int HI = (1 << TBITS) + 4;
	wire act = battery_present && charge_request_in && ce;
	wire fa = phase_flag_a;
	wire fb = phase_flag_b;
	logic [15:0] cnt;
	always @(posedge mclk)
	begin
		if (!nrst)
			cnt <= 16'h0000;
		else if ($rose(fb) && !fa)
			cnt <= 16'h0001;
		else
			cnt <= cnt + 16'h0001;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	a_start_cycle: assert property ($rose(charge_request_in)
		&& battery_present && ce && !charging |=> charging) else $error("no start");
	a_trickle_exit: assert property (charging && !fa && !fb
		&& trickle_sense_input && act |=> fa && !fb) else $error("no bulk");
	a_bulk_exit: assert property (charging && fa && !fb && volt_at_95
		&& act |=> !fa && fb) else $error("no over");
	a_near_full: assert property (charging && !fa && fb
		&& near_full_level && act |=> fa && fb) else $error("no near full");
	a_expiry_time: assert property ($rose(charge_request_oe)
		|-> cnt >= LO && cnt <= HI) else $error("expiry time");
	a_done_flags: assert property (charge_request_oe
		|-> !charging && !fa && !fb) else $error("done flags");
	a_drive_low: assert property (charge_request_out == 1'b0)
		else $error("pin data high");
	a_no_battery: assert property (!battery_present |=> !charging)
		else $error("charging without pack");
	a_freeze_hold: assert property (!ce |=>
		$stable({fa, fb, charging, charge_request_oe})) else $error("not frozen");
	a_apb_err: assert property (psel && penable && paddr > 12'h00C
		|-> pslverr && pready) else $error("unmapped ok");
endmodule // css_seq_props
bind css_sequencer css_seq_props #(.TBITS(TBITS)) u_props (.mclk, .nrst,
	.ce, .charge_request_in, .charge_request_out, .charge_request_oe,
	.trickle_sense_input, .volt_at_95, .near_full_level, .battery_present,
	.phase_flag_a, .phase_flag_b, .charging, .psel, .penable, .pready,
	.pslverr, .paddr);

/* testbench/css_sequencer_tb.sv */
// Purpose: Self-checking bench for the charge state sequencer
// Assumes: Timer shortened to 4 bits
// Notes:   Rows walk one full charge cycle
`timescale 1ns/1ps
module css_sequencer_tb;
	reg mclk = 0, nrst = 0, ce = 1, host_hi = 0, sense = 0, volt = 0;
	reg near = 0, bat = 1, psel = 0, penable = 0, pwrite = 0;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0;
	wire req, req_out, req_oe, fa, fb, charge_request, pready, pslverr;
	wire [31:0] prdata;
	int err_count = 0, samples_checked = 0, cycles = 0, k;
	logic [31:0] rd;
	logic er;
	logic [4:0] rows [0:4] = '{5'b00000, 5'b10010, 5'b11001, 5'b11111,
		5'b11011};
	css_host_model HOST (.drive_high(host_hi), .dev_oe(req_oe), .level(req));
	css_sequencer #(.TBITS(4)) DUT (.mclk(mclk), .nrst(nrst), .ce(ce),
		.charge_request_in(req), .charge_request_out(req_out),
		.charge_request_oe(req_oe), .trickle_sense_input(sense),
		.volt_at_95(volt), .near_full_level(near), .battery_present(bat),
		.phase_flag_a(fa), .phase_flag_b(fb), .charging(charge_request), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr));
	always #12.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			err_count++;
			give_verdict();
		end
	end
	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			err_count++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task do_reset;
		@(posedge mclk);
		host_hi <= 0;
		nrst <= 0;
		tick(3);
		nrst <= 1;
		tick(1);
	endtask
	task start(input logic s);
		sense <= s;
		volt <= 0;
		near <= 0;
		host_hi <= 1;
		tick(2);
		@(negedge mclk);
	endtask
	initial
	begin
		tick(3);
		nrst <= 1;
		tick(1);
		@(negedge mclk);
		chk("reset", {fa, fb, charge_request, req_oe}, 0);
		apb(0, 12'h00C, 0);
		chk("tdiv", rd, 32'h0000_0001);
		apb(1, 12'h00C, 32'h0000_0005);
		apb(0, 12'h00C, 0);
		chk("tdiv wr", rd, 32'h0000_0005);
		apb(0, 12'h010, 0);
		chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
		do_reset();
		$display("test registers done");
		start(0);
		for (int i = 0; i < 5; i++)
		begin
			@(posedge mclk);
			{sense, volt, near} <= rows[i][4:2];
			tick(2);
			@(negedge mclk);
			chk("flags", {fa, fb}, rows[i][1:0]);
		end
		chk("charging", charge_request, 1);
		k = 0;
		while (req_oe !== 1'b1 && k < 40)
		begin
			@(negedge mclk);
			k++;
		end
		chk("wire", {req_oe, req, fa, fb, charge_request}, 5'b10000);
		apb(0, 12'h004, 0);
		chk("status", rd, 32'h0000_0058);
		@(posedge mclk);
		bat <= 0;
		tick(2);
		@(negedge mclk);
		chk("release", {req_oe, req, charge_request}, 3'b010);
		@(posedge mclk);
		bat <= 1;
		$display("test cycle done");
		do_reset();
		start(1);
		chk("skip", {fa, fb, charge_request}, 3'b101);
		@(posedge mclk);
		bat <= 0;
		tick(1);
		@(negedge mclk);
		chk("removed", {fa, fb, charge_request}, 0);
		@(posedge mclk);
		host_hi <= 0;
		tick(2);
		host_hi <= 1;
		tick(2);
		bat <= 1;
		@(negedge mclk);
		chk("no pack", charge_request, 0);
		$display("test pack done");
		do_reset();
		start(0);
		@(posedge mclk);
		ce <= 0;
		sense <= 1;
		tick(4);
		@(negedge mclk);
		chk("frozen", {fa, fb, charge_request}, 3'b001);
		@(posedge mclk);
		ce <= 1;
		tick(2);
		@(negedge mclk);
		chk("thawed", {fa, fb}, 2'b10);
		$display("test freeze done");
		apb(1, 12'h000, 32'h0000_0001);
		apb(0, 12'h000, 0);
		chk("abort", {rd[0], fa, fb, charge_request}, 4'b1000);
		apb(1, 12'h000, 32'h0000_0000);
		apb(0, 12'h000, 0);
		chk("abort clr", {rd, charge_request}, 0);
		$display("test abort done");
		give_verdict();
	end
endmodule // css_sequencer_tb
